// >>> hdl/rmc_reset_mode_ctrl.sv
// rmc_reset_mode_ctrl: reset gathering, mode entry and low power control.
// assumes pins arrive asynchronously, core events arrive on ref_clk.
`timescale 1ns/1ps
module rmc_reset_mode_ctrl #(
	parameter int WDOG_SHORT = rmc_pkg::WDOG_SHORT_CYC,
	parameter int WDOG_LONG = rmc_pkg::WDOG_LONG_CYC,
	parameter int RESET_HOLD = 4
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic powerOnDetect,
	input wire logic lowVoltDetect,
	input wire logic lowVoltEnable,
	input wire logic resetPin_n,
	input wire logic resetPinEnable,
	input wire logic modeSelectDebugPin,
	input wire logic illegalOpcode,
	input wire logic illegalAddress,
	input wire logic hostResetCmd,
	input wire logic hostHaltCmd,
	input wire logic debugHaltInstruction,
	input wire logic debugCtrlBreak,
	input wire logic traceBreak,
	input wire logic resumeRun,
	input wire logic watchdogEnable,
	input wire logic watchdogLong,
	input wire logic watchdogService,
	input wire logic waitRequest,
	input wire logic stopRequest,
	input wire logic [1:0] stopDepth,
	input wire logic wakeEvent,
	input wire logic [7:0] memData,
	output logic [15:0] memAddr,
	output logic memRead,
	output logic [15:0] programCounter,
	output logic [15:0] stackPointer,
	output logic [7:0] conditionFlags,
	output logic coreReset,
	output logic cpuRun,
	output logic backgroundActive,
	output logic peripheralEnable,
	output logic pinPullupEnable,
	output logic pinOutputEnable,
	output logic clocksRunning,
	output logic regulatorFull,
	output logic ramPowered,
	output logic circuitsPowered,
	output logic [7:0] resetSourceStatus
);
	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	logic [3:0] syncA_ff; // first stage, read only by second
	logic [3:0] syncB_ff;
	logic [3:0] nxt_syncA;
	logic [3:0] nxt_syncB;
	logic resetPinSync_n; // external reset pin, synced
	logic modeSync; // mode select pin, synced
	logic powerOnSync;
	logic lowVoltSync;

	// pack raw pins into first stage
	always_comb begin
		nxt_syncA = {lowVoltDetect, powerOnDetect, modeSelectDebugPin, resetPin_n};
		nxt_syncB = syncA_ff;
	end

	// registers for synchronisers; idle values look harmless
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			syncA_ff <= 4'h3;
			syncB_ff <= 4'h3;
		end else begin
			syncA_ff <= nxt_syncA;
			syncB_ff <= nxt_syncB;
		end
	end

	assign resetPinSync_n = syncB_ff[0];
	assign modeSync = syncB_ff[1];
	assign powerOnSync = syncB_ff[2];
	assign lowVoltSync = syncB_ff[3];

	// ---------------------------------------------------------------
	// watchdog
	// ---------------------------------------------------------------
	logic wdogExpired; // one-cycle timeout pulse
	logic inDebug; // watchdog is held cleared while debugging

	rmc_watchdog #(
		.SHORT_CYC(WDOG_SHORT),
		.LONG_CYC(WDOG_LONG)
	) uWatchdog (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.enable(watchdogEnable),
		.longSel(watchdogLong),
		.service(watchdogService),
		.halted(inDebug),
		.expired(wdogExpired)
	);

	// ---------------------------------------------------------------
	// reset gathering
	// ---------------------------------------------------------------
	logic [rmc_pkg::SRC_COUNT-1:0] srcNow; // live source vector
	logic anySrc;
	logic [7:0] holdCnt_ff; // stretches the internal reset
	logic [7:0] nxt_holdCnt;
	logic [7:0] status_ff;
	logic [7:0] nxt_status;

	always_comb begin
		srcNow = '0;
		srcNow[rmc_pkg::SRC_POWERON] = powerOnSync;
		srcNow[rmc_pkg::SRC_PIN] = resetPinEnable & ~resetPinSync_n;
		srcNow[rmc_pkg::SRC_WATCHDOG] = wdogExpired;
		srcNow[rmc_pkg::SRC_ILLOP] = illegalOpcode;
		srcNow[rmc_pkg::SRC_ILLADR] = illegalAddress;
		srcNow[rmc_pkg::SRC_HOST] = hostResetCmd;
		srcNow[rmc_pkg::SRC_LOWVOLT] = lowVoltEnable & lowVoltSync;
		anySrc = |srcNow;
	end

	always_comb begin
		nxt_holdCnt = holdCnt_ff;
		nxt_status = status_ff;
		if (anySrc) begin
			nxt_holdCnt = 8'(RESET_HOLD);
			// latch the cause; power-on outranks all others
			if (holdCnt_ff == 8'h00) begin
				nxt_status = srcNow[rmc_pkg::SRC_POWERON] ?
					(8'h01 << rmc_pkg::SRC_POWERON) : srcNow;
				// several at once: keep the highest only
				for (int i = 0; i < rmc_pkg::SRC_COUNT; i++) begin
					if (srcNow[i]) begin
						nxt_status = 8'h01 << i;
					end
				end
			end
		end else if (holdCnt_ff != 8'h00) begin
			nxt_holdCnt = holdCnt_ff - 8'h01;
		end
	end

	// registers for reset stretching and cause
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			holdCnt_ff <= 8'(RESET_HOLD);
			status_ff <= 8'h80;
		end else begin
			holdCnt_ff <= nxt_holdCnt;
			status_ff <= nxt_status;
		end
	end

	// ---------------------------------------------------------------
	// mode sequencer and core state
	// ---------------------------------------------------------------
	rmc_pkg::rmc_mode_t mode_ff; // current operating mode
	rmc_pkg::rmc_mode_t nxt_mode;
	logic [15:0] pc_ff;
	logic [15:0] nxt_pc;
	logic [15:0] stack_ff;
	logic [15:0] nxt_stack;
	logic [7:0] flags_ff;
	logic [7:0] nxt_flags;
	logic [15:0] addr_ff;
	logic [15:0] nxt_addr;
	logic rd_ff;
	logic nxt_rd;
	logic debugReq; // any debug entry event
	logic inReset; // combined internal reset active

	assign inReset = anySrc | (holdCnt_ff != 8'h00);
	assign inDebug = (mode_ff == rmc_pkg::MODE_DEBUG);

	assign debugReq = hostHaltCmd | debugHaltInstruction | debugCtrlBreak | traceBreak;

	// next state of the sequencer
	always_comb begin
		nxt_mode = mode_ff;
		nxt_pc = pc_ff;
		nxt_stack = stack_ff;
		nxt_flags = flags_ff;
		nxt_addr = addr_ff;
		nxt_rd = 1'b0;
		if (inReset) begin
			nxt_mode = rmc_pkg::MODE_RESET;
			nxt_stack = rmc_pkg::STACK_RESET;
			nxt_flags = rmc_pkg::FLAGS_RESET;
			nxt_pc = '0;
			nxt_addr = '0;
		end else begin
			case (mode_ff)
				rmc_pkg::MODE_RESET: begin
					// low pin picks debug, high pin picks run
					if (!modeSync) begin
						nxt_mode = rmc_pkg::MODE_DEBUG;
					end else begin
						nxt_mode = rmc_pkg::MODE_FETCH_HI;
						nxt_addr = rmc_pkg::VEC_HI_ADDR;
						nxt_rd = 1'b1;
					end
				end
				rmc_pkg::MODE_FETCH_HI: begin
					// data for the high byte is taken in the same cycle that memRead is high
					nxt_pc = {memData, pc_ff[7:0]};
					nxt_mode = rmc_pkg::MODE_FETCH_LO;
					nxt_addr = rmc_pkg::VEC_LO_ADDR;
					nxt_rd = 1'b1;
				end
				rmc_pkg::MODE_FETCH_LO: begin
					// low byte completes the start address
					nxt_pc = {pc_ff[15:8], memData};
					nxt_mode = debugReq ? rmc_pkg::MODE_DEBUG : rmc_pkg::MODE_RUN;
				end
				rmc_pkg::MODE_RUN: begin
					// debug entry takes priority over low power requests
					if (debugReq) begin
						nxt_mode = rmc_pkg::MODE_DEBUG;
					end else if (stopRequest) begin
						nxt_mode = rmc_pkg::MODE_STOP;
					end else if (waitRequest) begin
						nxt_mode = rmc_pkg::MODE_WAIT;
					end
				end
				rmc_pkg::MODE_WAIT: begin
					if (debugReq) begin
						nxt_mode = rmc_pkg::MODE_DEBUG;
					end else if (wakeEvent) begin
						nxt_mode = rmc_pkg::MODE_RUN;
					end
				end
				rmc_pkg::MODE_STOP: begin
					// deeper stops leave only through reset
					if (wakeEvent && stopDepth == rmc_pkg::STOP_FAST) begin
						nxt_mode = rmc_pkg::MODE_RUN;
					end
				end
				rmc_pkg::MODE_DEBUG: begin
					// host releases the core back to run
					if (resumeRun) begin
						nxt_mode = rmc_pkg::MODE_RUN;
					end
				end
				default: begin
					nxt_mode = rmc_pkg::MODE_RESET;
				end
			endcase
		end
	end

	// registers for the sequencer
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			mode_ff <= rmc_pkg::MODE_RESET;
			pc_ff <= '0;
			stack_ff <= rmc_pkg::STACK_RESET;
			flags_ff <= rmc_pkg::FLAGS_RESET;
			addr_ff <= '0;
			rd_ff <= 1'b0;
		end else begin
			mode_ff <= nxt_mode;
			pc_ff <= nxt_pc;
			stack_ff <= nxt_stack;
			flags_ff <= nxt_flags;
			addr_ff <= nxt_addr;
			rd_ff <= nxt_rd;
		end
	end

	// ---------------------------------------------------------------
	// registered control outputs
	// ---------------------------------------------------------------
	logic [9:0] ctl_ff; // packed control outputs
	logic [9:0] nxt_ctl;
	logic stopHere;

	// decode mode into pad, power and clock controls
	always_comb begin
		stopHere = (mode_ff == rmc_pkg::MODE_STOP);
		nxt_ctl[0] = inReset | (mode_ff == rmc_pkg::MODE_RESET);
		nxt_ctl[1] = (mode_ff == rmc_pkg::MODE_RUN);
		nxt_ctl[2] = inDebug;
		nxt_ctl[3] = ~inReset & ~stopHere & (mode_ff != rmc_pkg::MODE_RESET);
		nxt_ctl[4] = ~inReset & (mode_ff != rmc_pkg::MODE_RESET);
		nxt_ctl[5] = ~inReset & (mode_ff != rmc_pkg::MODE_RESET);
		// clocks and regulator kept in wait
		nxt_ctl[6] = ~stopHere;
		nxt_ctl[7] = ~stopHere;
		nxt_ctl[8] = ~(stopHere && stopDepth == rmc_pkg::STOP_FULL);
		// only fast recovery keeps circuits powered
		nxt_ctl[9] = ~stopHere | (stopDepth == rmc_pkg::STOP_FAST);
	end

	// registers for control outputs
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			ctl_ff <= 10'h3C1;
		end else begin
			ctl_ff <= nxt_ctl;
		end
	end

	assign coreReset = ctl_ff[0];
	assign cpuRun = ctl_ff[1];
	assign backgroundActive = ctl_ff[2];
	assign peripheralEnable = ctl_ff[3];
	assign pinPullupEnable = ctl_ff[4];
	assign pinOutputEnable = ctl_ff[5];
	assign clocksRunning = ctl_ff[6];
	assign regulatorFull = ctl_ff[7];
	assign ramPowered = ctl_ff[8];
	assign circuitsPowered = ctl_ff[9];
	assign memAddr = addr_ff;
	assign memRead = rd_ff;
	assign programCounter = pc_ff;
	assign stackPointer = stack_ff;
	assign conditionFlags = flags_ff;
	assign resetSourceStatus = status_ff;
endmodule

// >>> include/rmc_pkg.sv
// rmc_pkg: constants for the reset and mode entry control block.
// assumes one 250 MHz system clock and a synchronous active-low reset.
package rmc_pkg;
	// ---------------------------------------------------------------
	// vectors and reset values
	// ---------------------------------------------------------------
	localparam logic [15:0] VEC_HI_ADDR = 16'hFFFE; // high byte of start address
	localparam logic [15:0] VEC_LO_ADDR = 16'hFFFF; // low byte of start address
	localparam logic [15:0] STACK_RESET = 16'h00FF; // stack pointer after reset
	localparam logic [7:0] FLAGS_RESET = 8'h68; // condition flags, mask bit set
	localparam int MASK_BIT_POS = 3; // interrupt mask position
	// ---------------------------------------------------------------
	// reset source status bit positions
	// ---------------------------------------------------------------
	localparam int SRC_POWERON = 7;
	localparam int SRC_PIN = 6;
	localparam int SRC_WATCHDOG = 5;
	localparam int SRC_ILLOP = 4;
	localparam int SRC_ILLADR = 3;
	localparam int SRC_HOST = 2;
	localparam int SRC_LOWVOLT = 1;
	localparam int SRC_COUNT = 8;
	// ---------------------------------------------------------------
	// watchdog timing
	// ---------------------------------------------------------------
	localparam int WDOG_SHORT_CYC = 8192; // short timeout, cycles
	localparam int WDOG_LONG_CYC = 262144; // long timeout, cycles
	localparam int WDOG_W = 18; // counter width
	// ---------------------------------------------------------------
	// operating modes, gray along reset, run, wait, stop
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		MODE_RESET = 3'h0,
		MODE_FETCH_HI = 3'h1,
		MODE_FETCH_LO = 3'h3,
		MODE_RUN = 3'h2,
		MODE_WAIT = 3'h6,
		MODE_STOP = 3'h7,
		MODE_DEBUG = 3'h5
	} rmc_mode_t;
	// stop depth codes
	localparam logic [1:0] STOP_FULL = 2'h1; // full powerdown
	localparam logic [1:0] STOP_RAM = 2'h2; // ram retaining
	localparam logic [1:0] STOP_FAST = 2'h3; // fast recovery
endpackage

// >>> hdl/rmc_watchdog.sv
// rmc_watchdog: operating watchdog counter with two timeouts.
// assumes the service pulse comes from logic on the same clock.
`timescale 1ns/1ps
module rmc_watchdog #(
	parameter int SHORT_CYC = rmc_pkg::WDOG_SHORT_CYC,
	parameter int LONG_CYC = rmc_pkg::WDOG_LONG_CYC
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic enable,
	input wire logic longSel,
	input wire logic service,
	input wire logic halted,
	output logic expired
);
	logic [rmc_pkg::WDOG_W-1:0] cnt_ff; // elapsed cycles
	logic [rmc_pkg::WDOG_W-1:0] nxt_cnt;
	logic [rmc_pkg::WDOG_W-1:0] limit; // chosen timeout
	logic expired_ff;
	logic nxt_expired;
	localparam int CW = rmc_pkg::WDOG_W; // local copy so the casts stay plain

	// ---------------------------------------------------------------
	// next-value logic
	// ---------------------------------------------------------------
	// enable and timeout choice
	always_comb begin
		limit = longSel ? CW'(LONG_CYC - 1) : CW'(SHORT_CYC - 1);
		nxt_cnt = cnt_ff;
		nxt_expired = 1'b0;
		// cleared to zero while disabled, serviced or in background
		if (!enable || service || halted) begin
			nxt_cnt = '0;
		end else if (cnt_ff >= limit) begin
			nxt_cnt = '0;
			nxt_expired = 1'b1;
		end else begin
			nxt_cnt = cnt_ff + 1'b1;
		end
	end

	// registers only
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			cnt_ff <= '0;
			expired_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			expired_ff <= nxt_expired;
		end
	end

	assign expired = expired_ff;
endmodule

// >>> verification/rmc_reset_mode_ctrl_asserts.sv
// rmc_checks: port checks for reset gathering and mode entry.
// assumes one clock domain and the block's own port names.
`timescale 1ns/1ps
module rmc_checks (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic hostHaltCmd,
	input wire logic debugHaltInstruction,
	input wire logic debugCtrlBreak,
	input wire logic traceBreak,
	input wire logic illegalOpcode,
	input wire logic illegalAddress,
	input wire logic hostResetCmd,
	input wire logic modeSelectDebugPin,
	input wire logic waitRequest,
	input wire logic stopRequest,
	input wire logic [1:0] stopDepth,
	input wire logic memRead,
	input wire logic [15:0] memAddr,
	input wire logic [15:0] stackPointer,
	input wire logic [7:0] conditionFlags,
	input wire logic coreReset,
	input wire logic cpuRun,
	input wire logic backgroundActive,
	input wire logic peripheralEnable,
	input wire logic pinPullupEnable,
	input wire logic pinOutputEnable,
	input wire logic clocksRunning,
	input wire logic regulatorFull,
	input wire logic ramPowered,
	input wire logic circuitsPowered,
	input wire logic [7:0] resetSourceStatus
);
	// one domain, so clock and disable are given once
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	// past term skips the edge where internal reset first rises
	a_pins_float: assert property (coreReset && $past(coreReset) |->
		!peripheralEnable && !pinPullupEnable && !pinOutputEnable) else $error("pins not floating in reset");
	a_stack_flags: assert property (coreReset && $past(coreReset) |->
		stackPointer == 16'h00FF && conditionFlags[3]) else $error("stack or mask wrong in reset");
	a_vec_order: assert property ($rose(memRead) |->
		memAddr == 16'hFFFE ##1 memAddr == 16'hFFFF) else $error("vector fetch order wrong");
	a_halt_debug_halt_instruction: assert property (cpuRun && (hostHaltCmd || debugHaltInstruction || debugCtrlBreak ||
		traceBreak) |-> ##[1:4] backgroundActive) else $error("halt did not enter background");
	a_src_reset: assert property (!coreReset && (illegalOpcode || illegalAddress || hostResetCmd)
		|-> ##[1:3] coreReset) else $error("reset source ignored");
	a_one_cause: assert property (!coreReset |-> $onehot(resetSourceStatus))
		else $error("status not one-hot");
	a_wait_clocks: assert property (cpuRun && waitRequest |->
		##[1:3] (!cpuRun && clocksRunning && regulatorFull)) else $error("wait state wrong");
	a_stop_full: assert property (cpuRun && stopRequest && stopDepth == 2'h1 |->
		##[1:3] (!circuitsPowered && !ramPowered)) else $error("full stop still powered");
	a_run_mode: assert property ($fell(coreReset) && modeSelectDebugPin |-> ##[1:8] cpuRun)
		else $error("run mode not entered");
	a_bg_mode: assert property ($fell(coreReset) && !modeSelectDebugPin |-> ##[0:8] backgroundActive)
		else $error("background not entered");
	cover property ($rose(backgroundActive));
	cover property ($rose(coreReset));
	cover property (!ramPowered);
endmodule
bind rmc_reset_mode_ctrl rmc_checks u_chk (.*);

// >>> verification/rmc_host_model.sv
// rmc_host_model: debug host on the mode pin plus vector memory.
// assumes bench requests arrive as one-cycle pulses on ref_clk.
`timescale 1ns/1ps
module rmc_host_model #(
	parameter logic [15:0] START = 16'hC123
) (
	input wire logic ref_clk,
	input wire logic modeLow,
	input wire logic haltReq,
	input wire logic rstReq,
	input wire logic memRead,
	input wire logic [15:0] memAddr,
	output logic modeSelectDebugPin,
	output logic hostHaltCmd,
	output logic hostResetCmd,
	output logic [7:0] memData
);
	logic [7:0] junk = 8'hA5; // changes every cycle so stale data never matches
	assign modeSelectDebugPin = !modeLow;
	assign memData = !memRead ? junk : (memAddr == 16'hFFFE) ? START[15:8] :
		(memAddr == 16'hFFFF) ? START[7:0] : ~junk;
	always @(posedge ref_clk) begin
		junk <= ~junk + 8'h01;
		hostHaltCmd <= haltReq;
		hostResetCmd <= rstReq;
	end
endmodule

// >>> verification/testbench.sv
// testbench: scenario tasks for reset and mode entry control.
// assumes the host model serves mode pin, host commands and vectors.
`timescale 1ns/1ps
module testbench;
	localparam logic [15:0] START = 16'hC123;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [11:0] ev = 12'h000; // one-cycle event pulses
	logic powerOnDetect = 1'b0, lowVoltDetect = 1'b0, lowVoltEnable = 1'b0, resetPinEnable = 1'b0;
	logic resetPin_n = 1'b1, watchdogEnable = 1'b0, watchdogLong = 1'b0, modeLow = 1'b0;
	logic [1:0] stopDepth = 2'h1;
	logic modeSelectDebugPin, hostHaltCmd, hostResetCmd, memRead, coreReset, cpuRun, backgroundActive;
	logic peripheralEnable, pinPullupEnable, pinOutputEnable, clocksRunning, regulatorFull;
	logic ramPowered, circuitsPowered;
	logic [7:0] memData, conditionFlags, resetSourceStatus;
	logic [15:0] memAddr, programCounter, stackPointer;
	wire logic illegalOpcode = ev[0], illegalAddress = ev[1], debugHaltInstruction = ev[2];
	wire logic debugCtrlBreak = ev[3], traceBreak = ev[4], resumeRun = ev[5], watchdogService = ev[6];
	wire logic waitRequest = ev[7], stopRequest = ev[8], wakeEvent = ev[9], haltReq = ev[10], rstReq = ev[11];
	int err_total = 0;
	int samples_checked = 0;
	// short watchdog counts keep the run brief
	rmc_reset_mode_ctrl #(.WDOG_SHORT(16), .WDOG_LONG(64)) DUT (.*);
	rmc_host_model #(.START(START)) host (.*);
	initial begin
		forever #2 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		samples_checked++;
		if (s !== e) begin
			err_total++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic pulse(input int i);
		@(posedge ref_clk);
		ev[i] <= 1'b1;
		@(posedge ref_clk);
		ev[i] <= 1'b0;
	endtask
	function automatic logic st(input int s);
		case (s)
			0: return cpuRun;
			1: return backgroundActive;
			2: return coreReset;
			default: return !coreReset;
		endcase
	endfunction
	// bounded wait, sampled on the falling edge where outputs are settled
	task automatic wt(input int s);
		int k;
		k = 0;
		@(negedge ref_clk);
		while (st(s) !== 1'b1 && k < 300) begin
			@(negedge ref_clk);
			k++;
		end
		if (k == 300) chk(16'h0, 16'h1);
	endtask
	task automatic rst(input logic ml);
		@(posedge ref_clk);
		reset_n <= 1'b0;
		modeLow <= ml;
		repeat (10) @(posedge ref_clk);
		chk(peripheralEnable | pinPullupEnable | pinOutputEnable, 1'b0);
		chk(resetSourceStatus, 8'h80);
		reset_n <= 1'b1;
	endtask
	task automatic boot();
		wt(3);
		wt(0);
		chk(programCounter, START);
		chk(stackPointer, 16'h00FF);
		chk(conditionFlags[3], 1'b1);
	endtask
	// a cause has fired: clear level sources, reboot, read status
	task automatic cause(input int b);
		wt(2);
		@(posedge ref_clk);
		lowVoltDetect <= 1'b0;
		resetPin_n <= 1'b1;
		powerOnDetect <= 1'b0;
		boot();
		chk(resetSourceStatus, 16'h1 << b);
	endtask
	task automatic t_bg();
		rst(1'b1);
		wt(3);
		wt(1);
		chk(cpuRun, 1'b0);
		@(posedge ref_clk);
		modeLow <= 1'b0;
		pulse(5);
		wt(0);
	endtask
	task automatic t_halts();
		int hs[4] = '{10, 2, 3, 4};
		foreach (hs[j]) begin
			pulse(hs[j]);
			wt(1);
			chk(backgroundActive, 1'b1);
			pulse(5);
			wt(0);
		end
	endtask
	task automatic t_src();
		int ps[3] = '{0, 1, 11};
		int bs[3] = '{4, 3, 2};
		for (int j = 0; j < 3; j++) begin
			pulse(ps[j]);
			cause(bs[j]);
		end
		@(posedge ref_clk);
		lowVoltDetect <= 1'b1;
		resetPin_n <= 1'b0;
		repeat (20) @(negedge ref_clk);
		chk(coreReset, 1'b0);
		@(posedge ref_clk);
		lowVoltEnable <= 1'b1;
		cause(1);
		@(posedge ref_clk);
		resetPinEnable <= 1'b1;
		resetPin_n <= 1'b0;
		cause(6);
		@(posedge ref_clk);
		powerOnDetect <= 1'b1;
		cause(7);
	endtask
	task automatic t_wdog();
		int k;
		@(posedge ref_clk);
		watchdogEnable <= 1'b1;
		watchdogLong <= 1'b1;
		repeat (5) begin
			repeat (30) @(negedge ref_clk);
			pulse(6);
		end
		chk(resetSourceStatus, 8'h80);
		cause(5);
		// short choice: service once, then count cycles until it bites
		@(posedge ref_clk);
		watchdogLong <= 1'b0;
		pulse(6);
		k = 0;
		while (coreReset !== 1'b1 && k < 40) begin
			@(negedge ref_clk);
			k++;
		end
		chk(k >= 16 && k <= 20, 1'b1);
		@(posedge ref_clk);
		watchdogEnable <= 1'b0;
		cause(5);
	endtask
	task automatic t_low();
		pulse(7);
		repeat (3) @(negedge ref_clk);
		chk({cpuRun, clocksRunning, regulatorFull}, 3'b011);
		pulse(9);
		wt(0);
		for (int d = 1; d < 4; d++) begin
			@(posedge ref_clk);
			stopDepth <= d[1:0];
			pulse(8);
			repeat (4) @(negedge ref_clk);
			chk({ramPowered, circuitsPowered}, {d != 1, d == 3});
			if (d == 3) pulse(9);
			else rst(1'b0);
			wt(0);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		rst(1'b0);
		boot();
		chk(cpuRun, 1'b1);
		t_bg();
		t_halts();
		t_src();
		t_wdog();
		t_low();
		end_sim();
	end
	// hang guard, far beyond the few hundred cycles the tests take
	initial begin
		#60000;
		chk(16'h0, 16'h1);
		end_sim();
	end
endmodule
